// File: rtid_pkg.sv
package rtid_pkg;
  // ==========================================
  // Opcodes
  localparam logic [9:0] OP_LOAD_TIMER3_RELOAD = 10'h23b;
  localparam logic [9:0] OP_LOAD_SERIAL_SHIFT = 10'h238;
  localparam logic [9:0] OP_LOAD_INT_CTRL_ONE = 10'h03f;
  localparam logic [9:0] OP_LOAD_INT_CTRL_TWO = 10'h03e;

  // ==========================================
  // Widths, fields and reset values
  localparam int NIB_W = 4;
  localparam int BYTE_W = 8;
  localparam int OP_W = 10;
  localparam int HI_LSB = 4;
  localparam int INSN_WORDS = 1;
  localparam int INSN_CYCLES = 1;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [3:0] INT_CTRL_RST = 4'h0;

  // ==========================================
  // Decoded operation
  typedef enum logic [2:0] {
    RTID_OP_NONE,
    RTID_OP_TIMER3,
    RTID_OP_SERIAL,
    RTID_OP_INT1,
    RTID_OP_INT2
  } rtid_op_e;
endpackage

// File: rtid_opcode_decoder.sv
`timescale 1ns/1ps
module rtid_opcode_decoder (
  // Opcode
  input wire logic [9:0] opcode_i,
  input wire logic valid_i,
  // Result
  output rtid_pkg::rtid_op_e op_o
);
  always_comb begin
    op_o = rtid_pkg::RTID_OP_NONE;
    if (valid_i) begin
      unique case (opcode_i)
        rtid_pkg::OP_LOAD_TIMER3_RELOAD: op_o = rtid_pkg::RTID_OP_TIMER3; // [RULE1]
        rtid_pkg::OP_LOAD_SERIAL_SHIFT: op_o = rtid_pkg::RTID_OP_SERIAL; // [RULE2]
        rtid_pkg::OP_LOAD_INT_CTRL_ONE: op_o = rtid_pkg::RTID_OP_INT1; // [RULE3]
        rtid_pkg::OP_LOAD_INT_CTRL_TWO: op_o = rtid_pkg::RTID_OP_INT2; // [RULE4]
        default: op_o = rtid_pkg::RTID_OP_NONE;
      endcase
    end
  end
endmodule

// File: rtid_reg_transfer.sv
// ==========================================
// Functional notes
// [RULE1] Opcode 0x23b loads the timer-three reload register: one word, one cycle, carry kept, no skip.
// [RULE2] Opcode 0x238 loads the serial shift register: one word, one cycle, carry kept, no skip.
// [RULE3] Opcode 0x03f copies the accumulator into interrupt-control register one in one cycle.
// [RULE4] Opcode 0x03e loads interrupt-control register two: one word, one cycle, carry kept, no skip.
// [RULE5] The reload load puts B in bits 7..4 and the accumulator in bits 3..0 together.
// [RULE6] The shift load puts B in bits 7..4 and the accumulator in bits 3..0 together.
// [RULE7] The control-two load replaces all four bits with the accumulator.
// [RULE8] Only the named destination changes; accumulator, B and carry are left alone.
`timescale 1ns/1ps
module rtid_reg_transfer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Fetch path
  input wire logic [9:0] opcode_i,
  input wire logic opcode_valid_i,
  // CPU registers
  input wire logic [3:0] acc_i,
  input wire logic [3:0] reg_b_i,
  // Peripheral registers
  output logic [7:0] timer_three_reload_o,
  output logic [7:0] serial_shift_o,
  output logic [3:0] int_ctrl_one_o,
  output logic [3:0] int_ctrl_two_o,
  // Execution status
  output logic done_o,
  output logic load_timer3_reload_op_o,
  output logic load_serial_shift_op_o,
  output logic load_int_ctrl_one_op_o,
  output logic load_int_ctrl_two_op_o,
  output logic skip_o,
  output logic carry_write_o
);
  // ==========================================
  // Internal state
  // Decode
  rtid_pkg::rtid_op_e op;
  logic [3:0] hit_d;
  logic reload_we;
  logic shift_we;
  logic ic1_we;
  logic ic2_we;

  // Destinations
  logic [7:0] reload_d;
  logic [7:0] reload_q;
  logic [7:0] shift_d;
  logic [7:0] shift_q;
  logic [3:0] ic1_d;
  logic [3:0] ic1_q;
  logic [3:0] ic2_d;
  logic [3:0] ic2_q;

  // Status
  logic [3:0] hit_q;
  logic done_d;
  logic done_q;
  logic skip_q;
  logic carry_write_q;

  // ==========================================
  // Opcode decode
  // Valid low or any other code decodes to no operation
  rtid_opcode_decoder u_dec (
    .opcode_i(opcode_i),
    .valid_i(opcode_valid_i),
    .op_o(op)
  );

  // ==========================================
  // Execute strobes
  // Bit order: timer three, serial, control one, control two
  for (genvar i = 0; i < 4; i++) begin : g_hit
    assign hit_d[i] = (op == rtid_pkg::rtid_op_e'(3'(i + 1))); // [RULE1] [RULE2] [RULE3] [RULE4]
  end

  // At most one strobe is high, since the decoder picks one operation
  assign done_d = |hit_d;

  // ==========================================
  // Destination write enables
  // One destination per instruction; every other register keeps its value
  assign reload_we = hit_d[0]; // [RULE8]
  assign shift_we = hit_d[1]; // [RULE8]
  assign ic1_we = hit_d[2]; // [RULE8]
  assign ic2_we = hit_d[3]; // [RULE8]

  // ==========================================
  // Timer-three reload register
  // Both nibbles land on one edge, so the timer never reloads half a value
  always_comb begin
    reload_d = reload_q;
    if (reload_we) begin
      reload_d[rtid_pkg::HI_LSB +: rtid_pkg::NIB_W] = reg_b_i; // [RULE5]
      reload_d[0 +: rtid_pkg::NIB_W] = acc_i; // [RULE5]
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reload_q <= rtid_pkg::RELOAD_RST;
    end else begin
      reload_q <= reload_d; // [RULE1]
    end
  end

  // ==========================================
  // Serial shift register
  // Same B:A packing as the reload register
  always_comb begin
    shift_d = shift_q;
    if (shift_we) begin
      shift_d[rtid_pkg::HI_LSB +: rtid_pkg::NIB_W] = reg_b_i; // [RULE6]
      shift_d[0 +: rtid_pkg::NIB_W] = acc_i; // [RULE6]
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_q <= rtid_pkg::SHIFT_RST;
    end else begin
      shift_q <= shift_d; // [RULE2]
    end
  end

  // ==========================================
  // Interrupt-control register one
  // Full four-bit copy, as for control register two
  always_comb begin
    ic1_d = ic1_q;
    if (ic1_we) begin
      ic1_d = acc_i; // [RULE3]
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ic1_q <= rtid_pkg::INT_CTRL_RST;
    end else begin
      ic1_q <= ic1_d; // [RULE3]
    end
  end

  // ==========================================
  // Interrupt-control register two
  always_comb begin
    ic2_d = ic2_q;
    if (ic2_we) begin
      ic2_d = acc_i; // [RULE7]
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ic2_q <= rtid_pkg::INT_CTRL_RST;
    end else begin
      ic2_q <= ic2_d; // [RULE4]
    end
  end

  // ==========================================
  // Completion pulse
  // Reset clears the pulse, so no false completion follows reset
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d; // [RULE1] [RULE2] [RULE3] [RULE4]
    end
  end

  // ==========================================
  // Per-instruction pulses
  // Same bit order as the execute strobes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hit_q <= 4'h0;
    end else begin
      hit_q <= hit_d; // [RULE1] [RULE2] [RULE3] [RULE4]
    end
  end

  // ==========================================
  // Skip request
  // Held in a flop so all status pins share one clock-to-out path
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= 1'b0; // [RULE1] [RULE2] [RULE3] [RULE4]
    end
  end

  // ==========================================
  // Carry write request
  // Carry, A and B belong to the CPU; this block only ever reads them
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      carry_write_q <= 1'b0;
    end else begin
      carry_write_q <= 1'b0; // [RULE8]
    end
  end

  // ==========================================
  // Outputs
  // Peripheral registers
  assign timer_three_reload_o = reload_q;
  assign serial_shift_o = shift_q;
  assign int_ctrl_one_o = ic1_q;
  assign int_ctrl_two_o = ic2_q;

  // Status
  assign done_o = done_q;
  assign load_timer3_reload_op_o = hit_q[0];
  assign load_serial_shift_op_o = hit_q[1];
  assign load_int_ctrl_one_op_o = hit_q[2];
  assign load_int_ctrl_two_op_o = hit_q[3];
  assign skip_o = skip_q;
  assign carry_write_o = carry_write_q;
endmodule

// File: rtid_reg_transfer_assertions.sv
`timescale 1ns/1ps
module rtid_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Design inputs
  input wire logic [9:0] opcode_i,
  input wire logic opcode_valid_i,
  input wire logic [3:0] acc_i,
  input wire logic [3:0] reg_b_i,
  // Destination registers
  input wire logic [7:0] timer_three_reload_o,
  input wire logic [7:0] serial_shift_o,
  input wire logic [3:0] int_ctrl_one_o,
  input wire logic [3:0] int_ctrl_two_o,
  // Status
  input wire logic done_o,
  input wire logic load_timer3_reload_op_o,
  input wire logic load_serial_shift_op_o,
  input wire logic load_int_ctrl_one_op_o,
  input wire logic load_int_ctrl_two_op_o,
  input wire logic skip_o,
  input wire logic carry_write_o
);
  wire logic [7:0] ba = {reg_b_i, acc_i};
  wire logic [23:0] r = {timer_three_reload_o, serial_shift_o, int_ctrl_one_o, int_ctrl_two_o};
  wire logic [3:0] e = {4{opcode_valid_i}} & {opcode_i == rtid_pkg::OP_LOAD_TIMER3_RELOAD,
    opcode_i == rtid_pkg::OP_LOAD_SERIAL_SHIFT, opcode_i == rtid_pkg::OP_LOAD_INT_CTRL_ONE,
    opcode_i == rtid_pkg::OP_LOAD_INT_CTRL_TWO};
  wire logic any_e = |e;
  wire logic [3:0] p = {load_timer3_reload_op_o, load_serial_shift_op_o, load_int_ctrl_one_op_o,
    load_int_ctrl_two_op_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_t3_load: assert property (e[3] |=> r[23:16] == $past(ba)) else $error("t3 load");
  a_si_load: assert property (e[2] |=> r[15:8] == $past(ba)) else $error("si load");
  a_one_load: assert property (e[1] |=> r[7:4] == $past(acc_i)) else $error("c1 load");
  a_two_load: assert property (e[0] |=> r[3:0] == $past(acc_i)) else $error("c2 load");
  a_t3_hold: assert property (!e[3] |=> $stable(r[23:16])) else $error("t3 hold");
  a_si_hold: assert property (!e[2] |=> $stable(r[15:8])) else $error("si hold");
  a_one_hold: assert property (!e[1] |=> $stable(r[7:4])) else $error("c1 hold");
  a_two_hold: assert property (!e[0] |=> $stable(r[3:0])) else $error("c2 hold");
  a_pulse_map: assert property (1'b1 |=> p == $past(e)) else $error("pulse map");
  a_done_pulse: assert property (1'b1 |=> done_o == $past(any_e)) else $error("done pulse");
  a_no_skip: assert property (!skip_o && !carry_write_o) else $error("skip or carry");
endmodule
bind rtid_reg_transfer rtid_chk chk (
  .clk_i(clk_i),
  .arst_n_i(arst_n_i),
  .opcode_i(opcode_i),
  .opcode_valid_i(opcode_valid_i),
  .acc_i(acc_i),
  .reg_b_i(reg_b_i),
  .timer_three_reload_o(timer_three_reload_o),
  .serial_shift_o(serial_shift_o),
  .int_ctrl_one_o(int_ctrl_one_o),
  .int_ctrl_two_o(int_ctrl_two_o),
  .done_o(done_o),
  .load_timer3_reload_op_o(load_timer3_reload_op_o),
  .load_serial_shift_op_o(load_serial_shift_op_o),
  .load_int_ctrl_one_op_o(load_int_ctrl_one_op_o),
  .load_int_ctrl_two_op_o(load_int_ctrl_two_op_o),
  .skip_o(skip_o),
  .carry_write_o(carry_write_o)
);

// File: rtid_fetch_model.sv
`timescale 1ns/1ps
module rtid_fetch_model (
  // Word: valid, opcode, B, accumulator
  input wire logic [18:0] word_i,
  // Fetch path and CPU registers
  output logic [9:0] opcode_o,
  output logic valid_o,
  output logic [3:0] acc_o,
  output logic [3:0] reg_b_o
);
  // Valid low stands for a slow fetch
  assign {valid_o, opcode_o, reg_b_o, acc_o} = word_i;
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [18:0] w = '0;
  logic [31:0] s = 32'h333b31b0;
  logic [30:0] e, x, q[$];
  int failures = 0, total_checks = 0;
  wire logic [9:0] o;
  wire logic v;
  wire logic [3:0] a, b;
  wire logic [30:0] g;
  localparam logic [9:0] OPS [4] = '{rtid_pkg::OP_LOAD_TIMER3_RELOAD, rtid_pkg::OP_LOAD_SERIAL_SHIFT,
    rtid_pkg::OP_LOAD_INT_CTRL_ONE, rtid_pkg::OP_LOAD_INT_CTRL_TWO};
  always #12.5 clk_i = ~clk_i;
  rtid_fetch_model fm (.word_i(w), .opcode_o(o), .valid_o(v), .acc_o(a), .reg_b_o(b));
  rtid_reg_transfer uut (.clk_i, .arst_n_i, .opcode_i(o), .opcode_valid_i(v), .acc_i(a), .reg_b_i(b),
    .timer_three_reload_o(g[23:16]), .serial_shift_o(g[15:8]), .int_ctrl_one_o(g[7:4]), .int_ctrl_two_o(g[3:0]),
    .done_o(g[24]), .skip_o(g[25]), .carry_write_o(g[26]), .load_timer3_reload_op_o(g[27]),
    .load_serial_shift_op_o(g[28]), .load_int_ctrl_one_op_o(g[29]), .load_int_ctrl_two_op_o(g[30]));
  function automatic logic [31:0] nx(input logic [31:0] r);
    return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
  endfunction
  task automatic complete_run;
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Bit 9 flipped gives a near-miss opcode
  task automatic step;
    @(negedge clk_i);
    s = nx(s);
    w = {s[31:29] != 3'h0, OPS[s[9:8]] ^ {s[10], 9'h000}, s[7:0]};
    e[30:24] = {4'(w[18] && !s[10]) << s[9:8], 3'(w[18] && !s[10])};
    if (w[18] && !s[10]) case (s[9:8])
      2'h0: e[23:16] = w[7:0];
      2'h1: e[15:8] = w[7:0];
      2'h2: e[7:4] = w[3:0];
      default: e[3:0] = w[3:0];
    endcase
    q.push_back(e);
  endtask
  always @(posedge clk_i) begin
    #1;
    if (q.size() > 0) begin
      x = q.pop_front();
      total_checks++;
      if (g !== x) begin
        failures++;
        $display("CHECK FAILED outputs exp %h got %h", x, g);
      end
    end
  end
  // Second pass starts with a reset in mid-run
  initial begin
    repeat (2) begin
      arst_n_i = 1'b0;
      w = '0;
      e = '0;
      repeat (8) @(negedge clk_i);
      arst_n_i = 1'b1;
      repeat (300) step;
      // Let the last note be checked before the next reset or the verdict
      @(negedge clk_i);
    end
    complete_run;
  end
  // About 620 cycles of tests; 1600 allowed
  initial begin
    #40000;
    failures++;
    complete_run;
  end
endmodule
